// ==== include/ntbipc_pkg.sv ====
/*
  Shared constants and types for the bridge mailbox, doorbell and
  interrupt block: register indexes, field positions, widths, encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ntbipc_pkg;

  // Geometry
  localparam int NSIDE = 2;
  localparam int NMSG = 4;
  localparam int NSCR = 2;
  localparam int NSRC = 13;
  localparam int NLINK_EVT = 6;
  localparam int NLINE = 4;
  localparam int DW = 32;
  localparam int AW = 5;
  localparam int RW = 4;
  localparam int MODE_W = 2;
  localparam int LINE_W = 2;
  localparam int SRC_PER_CTL = 8;
  localparam int ROUTE_W = NSRC * RW;
  localparam int CTL_HI_W = ROUTE_W - DW;

  // Side indexes
  localparam int SIDE_INT = 0;
  localparam int SIDE_EXT = 1;

  // Register indexes, one 32-bit word each
  localparam logic [AW-1:0] REG_OUT_MSG0 = 5'h00;
  localparam logic [AW-1:0] REG_IN_MSG0 = 5'h04;
  localparam logic [AW-1:0] REG_OUT_DBELL = 5'h08;
  localparam logic [AW-1:0] REG_IN_DBELL = 5'h09;
  localparam logic [AW-1:0] REG_SCRATCH0 = 5'h0A;
  localparam logic [AW-1:0] REG_INT_STS = 5'h0C;
  localparam logic [AW-1:0] REG_ROUTE_LOW = 5'h0D;
  localparam logic [AW-1:0] REG_ROUTE_HIGH = 5'h0E;
  localparam logic [AW-1:0] REG_IRQ_CFG = 5'h0F;
  localparam logic [AW-1:0] REG_MSI_ADDR = 5'h10;
  localparam logic [AW-1:0] REG_MSI_DATA = 5'h11;
  localparam logic [AW-1:0] REG_TLP_CTL = 5'h12;

  // Interrupt status bit positions
  localparam int STS_MSG0 = 0;
  localparam int STS_DBELL = 4;
  localparam int STS_OPP_RST = 5;
  localparam int STS_OPP_PM = 6;
  localparam int STS_LINK0 = 7;

  // Route field encodings: mode in [1:0], legacy line in [3:2]
  localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
  localparam logic [MODE_W-1:0] MODE_INTX = 2'h1;
  localparam logic [MODE_W-1:0] MODE_MSI = 2'h2;

  // Interrupt configuration bits
  localparam int CFG_MSI_EN = 0;
  localparam int CFG_INTX_DIS = 1;
  localparam int CFG_W = 2;

  // TLP attribute override control bits
  localparam int TLP_FORCE_RO = 0;
  localparam int TLP_RO_VAL = 1;
  localparam int TLP_FORCE_NS = 2;
  localparam int TLP_NS_VAL = 3;
  localparam int TLP_CTL_W = 4;

  // Reset values
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;

  // Kinds of TLP crossing the bridge
  typedef enum logic [2:0] {
    TLP_MEM = 3'h0,
    TLP_IO = 3'h1,
    TLP_CFG = 3'h2,
    TLP_MSG = 3'h3,
    TLP_CPL = 3'h4
  } ntbipc_tlp_kind_t;

endpackage

// ==== include/ntbipc_irq_if.sv ====
/*
  Carrier between the register core and one interrupt message generator.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface ntbipc_irq_if;
  import ntbipc_pkg::*;
  logic [NSRC-1:0] sts;
  logic [ROUTE_W-1:0] route;
  logic msi_en;
  logic intx_dis;
  logic msi_send;
  logic [NLINE-1:0] intx_assert;
  logic [NLINE-1:0] intx_deassert;
  modport gen (
    input sts, route, msi_en, intx_dis,
    output msi_send, intx_assert, intx_deassert
  );
  modport core (
    output sts, route, msi_en, intx_dis,
    input msi_send, intx_assert, intx_deassert
  );
endinterface

// ==== hdl/ntbipc_irq_gen.sv ====
/*
  Interrupt message generator for one bridge endpoint: folds routed
  status bits into one MSI request and four legacy line requests and
  emits message strobes on their edges, one cycle long while ce is high.
  Assumes status, route and enables arrive from flops in ref_clk domain.
*/
`timescale 1ns/1ps
module ntbipc_irq_gen
  import ntbipc_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Core side
  ntbipc_irq_if.gen irq
);

  typedef struct packed {
    logic msi_req;
    logic [NLINE-1:0] line_req;
    logic msi_send;
    logic [NLINE-1:0] asrt;
    logic [NLINE-1:0] deas;
  } ntbipc_gen_st_t;

  ntbipc_gen_st_t cur;
  ntbipc_gen_st_t next_st;

  // Mode and line of one source out of the packed route word
  function automatic logic [MODE_W-1:0] src_mode(input logic [ROUTE_W-1:0] r, input int i);
    return r[i*RW +: MODE_W];
  endfunction

  function automatic logic [LINE_W-1:0] src_line(input logic [ROUTE_W-1:0] r, input int i);
    return r[i*RW+MODE_W +: LINE_W];
  endfunction

  // Requests rebuilt every cycle, so a route change acts at once
  always_comb begin
    logic msi;
    logic [NLINE-1:0] line;
    msi = 1'b0;
    line = '0;
    next_st = cur;
    for (int i = 0; i < NSRC; i++) begin
      if (irq.sts[i] && src_mode(irq.route, i) == MODE_MSI) begin
        msi = 1'b1; // [RULE13] [RULE17]
      end
      if (irq.sts[i] && src_mode(irq.route, i) == MODE_INTX) begin
        line[src_line(irq.route, i)] = 1'b1; // [RULE13] [RULE18]
      end
    end
    msi = msi & irq.msi_en; // [RULE14]
    // MSI enable does not gate legacy lines; software keeps them apart
    line = line & {NLINE{~irq.intx_dis}}; // [RULE15] [RULE16]
    next_st.msi_req = msi; // [RULE23]
    next_st.line_req = line;
    next_st.msi_send = msi & ~cur.msi_req; // [RULE17]
    next_st.asrt = line & ~cur.line_req; // [RULE18]
    next_st.deas = ~line & cur.line_req; // [RULE18]
  end

  // Strobes stretch while ce is low since all state freezes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_st;
    end
  end

  assign irq.msi_send = cur.msi_send;
  assign irq.intx_assert = cur.asrt;
  assign irq.intx_deassert = cur.deas;

endmodule // ntbipc_irq_gen

// ==== hdl/ntbipc_ipc_top.sv ====
/*
  Interprocessor communication core of a non-transparent bridge:
  message mirrors, doorbells, shared scratchpads, interrupt status and
  routing for both endpoints, and TLP attribute overrides.
  Assumes both configuration ports and all event inputs are synchronous
  to ref_clk; side 0 is the internal endpoint, side 1 the external one.
*/
// Behaviour
// [RULE1] Each side has four outbound and four inbound message registers.
// [RULE2] Outbound messages read and write; inbound messages are read only.
// [RULE3] Outbound write loads opposite inbound message and sets its status.
// [RULE4] Each side has a 32-bit outbound doorbell and an inbound doorbell.
// [RULE5] Inbound doorbell bit sets only on opposite outbound bit rising.
// [RULE6] Writing one clears an inbound doorbell bit; zero leaves it.
// [RULE7] Any set inbound doorbell bit sets that side's doorbell status.
// [RULE8] Two scratchpads shared by both sides, visible at once, no events.
// [RULE9] Software must not reach scratchpads via the extended data window.
// [RULE10] Thirteen sources: four messages, doorbell, reset, power, six link.
// [RULE11] Internal side signals upstream; external side over its own link.
// [RULE12] Each source has a field picking MSI, legacy line or disabled.
// [RULE13] Legacy routing picks line A to D; MSI sources share one vector.
// [RULE14] MSI source counts only while status set and MSI enabled.
// [RULE15] Legacy source counts only while status set and not disabled.
// [RULE16] Legacy messages stay possible while MSI is enabled.
// [RULE17] ORed MSI request sends one MSI per false-to-true change.
// [RULE18] Per-line ORed request sends assert on rise, deassert on fall.
// [RULE19] TLPs the endpoints originate keep their attributes.
// [RULE20] Force ordering replaces relaxed-ordering bit with held value.
// [RULE21] Force snoop replaces no-snoop bit with held value.
// [RULE22] Overrides skip config, I/O and message requests; memory writes apply.
// [RULE23] Status bits stick until written one; requests recomputed each clock.
`timescale 1ns/1ps
module ntbipc_ipc_top
  import ntbipc_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Configuration access, one port per side
  input wire logic [NSIDE-1:0] cfg_wr,
  input wire logic [NSIDE-1:0] cfg_rd,
  input wire logic [NSIDE-1:0][AW-1:0] cfg_addr,
  input wire logic [NSIDE-1:0][DW-1:0] cfg_wdata,
  output logic [NSIDE-1:0][DW-1:0] cfg_rdata,
  output logic [NSIDE-1:0] cfg_rvalid,
  // Interrupt events seen by each side
  input wire logic [NSIDE-1:0] evt_opp_reset,
  input wire logic [NSIDE-1:0] evt_opp_pm,
  input wire logic [NSIDE-1:0][NLINK_EVT-1:0] evt_link,
  // Message requests: side 0 upstream, side 1 onto the bridge link
  output logic [NSIDE-1:0] msi_send,
  output logic [NSIDE-1:0][DW-1:0] msi_addr,
  output logic [NSIDE-1:0][DW-1:0] msi_data,
  output logic [NSIDE-1:0][NLINE-1:0] intx_assert,
  output logic [NSIDE-1:0][NLINE-1:0] intx_deassert,
  // TLPs crossing the bridge
  input wire logic tlp_in_valid,
  input wire ntbipc_tlp_kind_t tlp_in_kind,
  input wire logic tlp_in_local,
  input wire logic tlp_in_ro,
  input wire logic tlp_in_ns,
  output logic tlp_out_valid,
  output logic tlp_out_ro,
  output logic tlp_out_ns
);

  typedef struct packed {
    logic [NSIDE-1:0][NMSG-1:0][DW-1:0] out_msg;
    logic [NSIDE-1:0][NMSG-1:0][DW-1:0] in_msg;
    logic [NSIDE-1:0][DW-1:0] out_dbell;
    logic [NSIDE-1:0][DW-1:0] in_dbell;
    logic [NSCR-1:0][DW-1:0] scratch;
    logic [NSIDE-1:0][NSRC-1:0] sts;
    logic [NSIDE-1:0][DW-1:0] route_low;
    logic [NSIDE-1:0][CTL_HI_W-1:0] route_high;
    logic [NSIDE-1:0][CFG_W-1:0] irq_cfg;
    logic [NSIDE-1:0][DW-1:0] msi_addr;
    logic [NSIDE-1:0][DW-1:0] msi_data;
    logic [TLP_CTL_W-1:0] tlp_ctl;
    logic [NSIDE-1:0][DW-1:0] rdata;
    logic [NSIDE-1:0] rvalid;
    logic tlp_valid;
    logic tlp_ro;
    logic tlp_ns;
  } ntbipc_st_t;

  ntbipc_st_t cur;
  ntbipc_st_t next_st;

  ntbipc_irq_if irq_if [NSIDE] ();

  // True when the address falls in a block of count words from base
  function automatic logic in_block(input logic [AW-1:0] a, input logic [AW-1:0] base,
                                    input int count);
    return (a >= base) && (int'(a) < int'(base) + count);
  endfunction

  // Word index inside a block
  function automatic int blk_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
    return int'(a - base);
  endfunction

  // Register read mux for one side; unmapped words read zero
  function automatic logic [DW-1:0] read_word(input ntbipc_st_t st, input int s,
                                              input logic [AW-1:0] a);
    logic [DW-1:0] v;
    v = RST_WORD;
    if (in_block(a, REG_OUT_MSG0, NMSG)) begin
      v = st.out_msg[s][blk_idx(a, REG_OUT_MSG0)];
    end else if (in_block(a, REG_IN_MSG0, NMSG)) begin
      v = st.in_msg[s][blk_idx(a, REG_IN_MSG0)];
    end else if (in_block(a, REG_SCRATCH0, NSCR)) begin
      v = st.scratch[blk_idx(a, REG_SCRATCH0)]; // [RULE8]
    end else begin
      case (a)
        REG_OUT_DBELL: v = st.out_dbell[s];
        REG_IN_DBELL: v = st.in_dbell[s];
        REG_INT_STS: v[NSRC-1:0] = st.sts[s];
        REG_ROUTE_LOW: v = st.route_low[s];
        REG_ROUTE_HIGH: v[CTL_HI_W-1:0] = st.route_high[s];
        REG_IRQ_CFG: v[CFG_W-1:0] = st.irq_cfg[s];
        REG_MSI_ADDR: v = st.msi_addr[s];
        REG_MSI_DATA: v = st.msi_data[s];
        REG_TLP_CTL: v[TLP_CTL_W-1:0] = st.tlp_ctl;
        default: v = RST_WORD;
      endcase
    end
    return v;
  endfunction

  // Register writes, mirrors, doorbells and sticky status
  always_comb begin
    logic [NSIDE-1:0][NMSG-1:0] msg_evt;
    logic [NSIDE-1:0][DW-1:0] db_set;
    logic [NSIDE-1:0][DW-1:0] db_clr;
    logic [NSIDE-1:0][NSRC-1:0] sts_clr;
    logic [NSIDE-1:0][NSRC-1:0] sts_set;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    int o;
    msg_evt = '0;
    db_set = '0;
    db_clr = '0;
    sts_clr = '0;
    sts_set = '0;
    a = '0;
    d = RST_WORD;
    o = 0;
    next_st = cur;
    next_st.rvalid = '0;
    // External side first so the internal side wins a scratchpad clash
    for (int s = NSIDE - 1; s >= 0; s--) begin
      a = cfg_addr[s];
      d = cfg_wdata[s];
      o = NSIDE - 1 - s;
      if (cfg_rd[s]) begin
        next_st.rdata[s] = read_word(cur, s, a);
        next_st.rvalid[s] = 1'b1;
      end
      if (cfg_wr[s]) begin
        if (in_block(a, REG_OUT_MSG0, NMSG)) begin
          next_st.out_msg[s][blk_idx(a, REG_OUT_MSG0)] = d; // [RULE1] [RULE2]
          next_st.in_msg[o][blk_idx(a, REG_OUT_MSG0)] = d; // [RULE3]
          msg_evt[o][blk_idx(a, REG_OUT_MSG0)] = 1'b1; // [RULE3]
        end else if (in_block(a, REG_SCRATCH0, NSCR)) begin
          next_st.scratch[blk_idx(a, REG_SCRATCH0)] = d; // [RULE8]
        end else begin
          // Inbound messages fall to default: read only
          case (a)
            REG_OUT_DBELL: begin
              next_st.out_dbell[s] = d; // [RULE4]
              db_set[o] = d & ~cur.out_dbell[s]; // [RULE5]
            end
            REG_IN_DBELL: db_clr[s] = d; // [RULE6]
            REG_INT_STS: sts_clr[s] = d[NSRC-1:0]; // [RULE23]
            REG_ROUTE_LOW: next_st.route_low[s] = d; // [RULE12]
            REG_ROUTE_HIGH: next_st.route_high[s] = d[CTL_HI_W-1:0]; // [RULE12]
            REG_IRQ_CFG: next_st.irq_cfg[s] = d[CFG_W-1:0];
            REG_MSI_ADDR: next_st.msi_addr[s] = d;
            REG_MSI_DATA: next_st.msi_data[s] = d;
            REG_TLP_CTL: begin
              if (s == SIDE_INT) begin
                next_st.tlp_ctl = d[TLP_CTL_W-1:0];
              end
            end
            default: next_st.rdata[s] = next_st.rdata[s];
          endcase
        end
      end
    end
    // Set beats clear so no event is lost to a racing write
    for (int s = 0; s < NSIDE; s++) begin
      next_st.in_dbell[s] = (cur.in_dbell[s] & ~db_clr[s]) | db_set[s]; // [RULE5] [RULE6]
      sts_set[s][STS_MSG0 +: NMSG] = msg_evt[s]; // [RULE10]
      sts_set[s][STS_DBELL] = |next_st.in_dbell[s]; // [RULE7]
      sts_set[s][STS_OPP_RST] = evt_opp_reset[s]; // [RULE10]
      sts_set[s][STS_OPP_PM] = evt_opp_pm[s]; // [RULE10]
      sts_set[s][STS_LINK0 +: NLINK_EVT] = evt_link[s]; // [RULE10]
      next_st.sts[s] = (cur.sts[s] & ~sts_clr[s]) | sts_set[s]; // [RULE23]
    end
    // Attribute override path, one register stage
    next_st.tlp_valid = tlp_in_valid;
    next_st.tlp_ro = tlp_in_ro;
    next_st.tlp_ns = tlp_in_ns;
    // MSIs look like memory writes here, so they are overridden too
    if (!tlp_in_local && tlp_in_kind != TLP_CFG && tlp_in_kind != TLP_IO
        && tlp_in_kind != TLP_MSG) begin // [RULE19] [RULE22]
      if (cur.tlp_ctl[TLP_FORCE_RO]) begin
        next_st.tlp_ro = cur.tlp_ctl[TLP_RO_VAL]; // [RULE20]
      end
      if (cur.tlp_ctl[TLP_FORCE_NS]) begin
        next_st.tlp_ns = cur.tlp_ctl[TLP_NS_VAL]; // [RULE21]
      end
    end
  end

  // Single state register; ce low freezes everything
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_st;
    end
  end

  // One generator per endpoint, fed from the status and route flops
  for (genvar g = 0; g < NSIDE; g++) begin : g_irq
    assign irq_if[g].sts = cur.sts[g];
    assign irq_if[g].route = {cur.route_high[g], cur.route_low[g]}; // [RULE12]
    assign irq_if[g].msi_en = cur.irq_cfg[g][CFG_MSI_EN];
    assign irq_if[g].intx_dis = cur.irq_cfg[g][CFG_INTX_DIS];

    ntbipc_irq_gen u_gen (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .irq(irq_if[g])
    );

    // Side 0 strobes go upstream, side 1 strobes onto the link
    assign msi_send[g] = irq_if[g].msi_send; // [RULE11]
    assign intx_assert[g] = irq_if[g].intx_assert; // [RULE11]
    assign intx_deassert[g] = irq_if[g].intx_deassert; // [RULE11]
  end

  // Outputs straight from the state register
  assign cfg_rdata = cur.rdata;
  assign cfg_rvalid = cur.rvalid;
  assign msi_addr = cur.msi_addr;
  assign msi_data = cur.msi_data;
  assign tlp_out_valid = cur.tlp_valid;
  assign tlp_out_ro = cur.tlp_ro;
  assign tlp_out_ns = cur.tlp_ns;

endmodule // ntbipc_ipc_top

// ==== tb/ntbipc_ipc_chk.sv ====
/*
  Concurrent checks on the ports of ntbipc_ipc_top, bound by name.
  Assumes one clock domain and ce held high during traffic.
*/
`timescale 1ns/1ps
module ntbipc_ipc_chk
  import ntbipc_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Config ports
  input wire logic [NSIDE-1:0] cfg_wr,
  input wire logic [NSIDE-1:0] cfg_rd,
  input wire logic [NSIDE-1:0][AW-1:0] cfg_addr,
  input wire logic [NSIDE-1:0][DW-1:0] cfg_wdata,
  input wire logic [NSIDE-1:0][DW-1:0] cfg_rdata,
  input wire logic [NSIDE-1:0] cfg_rvalid,
  // Message strobes
  input wire logic [NSIDE-1:0] msi_send,
  input wire logic [NSIDE-1:0][NLINE-1:0] intx_assert,
  input wire logic [NSIDE-1:0][NLINE-1:0] intx_deassert,
  // TLP path
  input wire logic tlp_in_valid,
  input wire ntbipc_tlp_kind_t tlp_in_kind,
  input wire logic tlp_in_local,
  input wire logic tlp_in_ro,
  input wire logic tlp_in_ns,
  input wire logic tlp_out_valid,
  input wire logic tlp_out_ro,
  input wire logic tlp_out_ns
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Line levels rebuilt from the message stream
  logic [2*NLINE-1:0] line_on;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_on <= '0;
    end else begin
      line_on <= (line_on | intx_assert) & ~intx_deassert;
    end
  end

  // Sequences: two accesses that write on one side and read two cycles later, then attributes passed unchanged
  sequence s_msg_mirror;
    (cfg_wr[0] && cfg_addr[0] == REG_OUT_MSG0) ##2 (cfg_rd[1] && cfg_addr[1] == REG_IN_MSG0);
  endsequence
  sequence s_scr_share;
    (cfg_wr[1] && cfg_addr[1] == REG_SCRATCH0) ##2 (cfg_rd[0] && cfg_addr[0] == REG_SCRATCH0);
  endsequence
  sequence s_attr_kept;
    tlp_out_valid && tlp_out_ro == $past(tlp_in_ro) && tlp_out_ns == $past(tlp_in_ns);
  endsequence

  property p_rd_answer; ce |=> cfg_rvalid == $past(cfg_rd); endproperty
  property p_msg_mirror; s_msg_mirror |=> cfg_rdata[1] == $past(cfg_wdata[0], 3); endproperty
  property p_scr_share; s_scr_share |=> cfg_rdata[0] == $past(cfg_wdata[1], 3); endproperty
  property p_msi_pulse; (msi_send & $past(msi_send)) == '0; endproperty
  property p_intx_pair; ((intx_assert & line_on) | (intx_deassert & ~line_on)) == '0; endproperty
  property p_local_keep; tlp_in_valid && tlp_in_local |=> s_attr_kept; endproperty
  property p_kind_skip;
    tlp_in_valid && !(tlp_in_kind inside {TLP_MEM, TLP_CPL}) |=> s_attr_kept;
  endproperty
  property p_reset_quiet;
    $rose(rst_b) |-> msi_send == '0 && intx_assert == '0 && cfg_rvalid == '0 && !tlp_out_valid;
  endproperty

  a_rd_answer: assert property (p_rd_answer) else $error("read answer timing wrong");
  a_msg_mirror: assert property (p_msg_mirror) else $error("inbound mirror wrong");
  a_scr_share: assert property (p_scr_share) else $error("scratchpad not shared");
  a_msi_pulse: assert property (p_msi_pulse) else $error("msi strobe too long");
  a_intx_pair: assert property (p_intx_pair) else $error("legacy message out of order");
  a_local_keep: assert property (p_local_keep) else $error("local tlp modified");
  a_kind_skip: assert property (p_kind_skip) else $error("skipped kind modified");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset");
endmodule // ntbipc_ipc_chk

bind ntbipc_ipc_top ntbipc_ipc_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .msi_send(msi_send),
  .intx_assert(intx_assert), .intx_deassert(intx_deassert), .tlp_in_valid(tlp_in_valid),
  .tlp_in_kind(tlp_in_kind), .tlp_in_local(tlp_in_local), .tlp_in_ro(tlp_in_ro),
  .tlp_in_ns(tlp_in_ns), .tlp_out_valid(tlp_out_valid), .tlp_out_ro(tlp_out_ro),
  .tlp_out_ns(tlp_out_ns));

// ==== tb/ntbipc_root_model.sv ====
/*
  Both roots as seen by the block: count MSIs, follow legacy lines.
  Assumes message strobes are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module ntbipc_root_model
  import ntbipc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Messages from both endpoints
  input wire logic [NSIDE-1:0] msi_send,
  input wire logic [NSIDE-1:0][NLINE-1:0] intx_assert,
  input wire logic [NSIDE-1:0][NLINE-1:0] intx_deassert,
  // What each root has seen
  output logic [NSIDE-1:0][7:0] msi_cnt,
  output logic [NSIDE-1:0][NLINE-1:0] intx_level
);
  // Legacy messages taken whatever the MSI state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      msi_cnt <= '0;
      intx_level <= '0;
    end else begin
      for (int s = 0; s < NSIDE; s++) begin
        msi_cnt[s] <= msi_cnt[s] + 8'(msi_send[s]);
      end
      intx_level <= (intx_level | intx_assert) & ~intx_deassert;
    end
  end
endmodule // ntbipc_root_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench for ntbipc_ipc_top with both roots modelled.
  Assumes the bound checker and the root model alongside.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import ntbipc_pkg::*;
  logic ref_clk, rst_b, ce, tlp_in_valid, tlp_in_local, tlp_in_ro, tlp_in_ns;
  logic tlp_out_valid, tlp_out_ro, tlp_out_ns;
  logic [NSIDE-1:0] cfg_wr, cfg_rd, cfg_rvalid, msi_send, evt_opp_reset, evt_opp_pm;
  logic [NSIDE-1:0][AW-1:0] cfg_addr;
  logic [NSIDE-1:0][DW-1:0] cfg_wdata, cfg_rdata, msi_addr, msi_data;
  logic [NSIDE-1:0][NLINK_EVT-1:0] evt_link;
  logic [NSIDE-1:0][NLINE-1:0] intx_assert, intx_deassert, intx_level;
  logic [NSIDE-1:0][7:0] msi_cnt;
  ntbipc_tlp_kind_t tlp_in_kind;
  int fails, checks;
  logic [31:0] seed, d, r;
  logic [3:0] ctl;
  logic [7:0] c0;
  logic exp_ro, exp_ns;

  ntbipc_ipc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .evt_opp_reset(evt_opp_reset), .evt_opp_pm(evt_opp_pm),
    .evt_link(evt_link), .msi_send(msi_send), .msi_addr(msi_addr), .msi_data(msi_data),
    .intx_assert(intx_assert), .intx_deassert(intx_deassert), .tlp_in_valid(tlp_in_valid),
    .tlp_in_kind(tlp_in_kind), .tlp_in_local(tlp_in_local), .tlp_in_ro(tlp_in_ro),
    .tlp_in_ns(tlp_in_ns), .tlp_out_valid(tlp_out_valid), .tlp_out_ro(tlp_out_ro),
    .tlp_out_ns(tlp_out_ns));
  ntbipc_root_model u_roots (.ref_clk(ref_clk), .rst_b(rst_b), .msi_send(msi_send),
    .intx_assert(intx_assert), .intx_deassert(intx_deassert), .msi_cnt(msi_cnt),
    .intx_level(intx_level));

  // Repeatable random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Attribute after the bridge: only foreign memory or completion TLPs change
  function automatic logic exp_attr(ntbipc_tlp_kind_t k, logic loc, logic v, logic f, logic n);
    return (!loc && f && (k == TLP_MEM || k == TLP_CPL)) ? n : v;
  endfunction

  task automatic wr(int s, logic [AW-1:0] a, logic [DW-1:0] v);
    @(posedge ref_clk);
    cfg_wr[s] <= 1'b1;
    cfg_addr[s] <= a;
    cfg_wdata[s] <= v;
    @(posedge ref_clk);
    cfg_wr[s] <= 1'b0;
  endtask
  // Read data lands just after the taking edge
  task automatic rd(int s, logic [AW-1:0] a, logic [DW-1:0] e, string nm);
    @(posedge ref_clk);
    cfg_rd[s] <= 1'b1;
    cfg_addr[s] <= a;
    @(posedge ref_clk);
    cfg_rd[s] <= 1'b0;
    #1;
    `CHK(nm, e, cfg_rdata[s])
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    fails++;
    end_sim();
  end

  initial begin
    {rst_b, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, evt_opp_reset, evt_opp_pm, evt_link} = '0;
    {tlp_in_valid, tlp_in_local, tlp_in_ro, tlp_in_ns, fails, checks} = '0;
    ce = 1'b1;
    tlp_in_kind = TLP_MEM;
    seed = 32'h0000_004C;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int s = 0; s < NSIDE; s++) begin
      for (int a = 0; a <= 18; a++) rd(s, AW'(a), RST_WORD, "reset_val");
    end
    rd(0, 5'h1F, RST_WORD, "unmapped");
    // Message mirrors, all four in both directions
    for (int s = 0; s < NSIDE; s++) begin
      for (int k = 0; k < NMSG; k++) begin
        d = rnd();
        wr(s, REG_OUT_MSG0 + AW'(k), d);
        rd(1 - s, REG_IN_MSG0 + AW'(k), d, "in_msg");
        rd(s, REG_OUT_MSG0 + AW'(k), d, "out_msg");
        wr(1 - s, REG_IN_MSG0 + AW'(k), ~d);
        rd(1 - s, REG_IN_MSG0 + AW'(k), d, "in_msg_ro");
        rd(1 - s, REG_INT_STS, DW'(1) << k, "msg_sts");
        wr(1 - s, REG_INT_STS, DW'(1) << k);
        rd(1 - s, REG_INT_STS, RST_WORD, "sts_clr");
      end
    end
    // Doorbells: set on rise only, write one to clear
    for (int s = 0; s < NSIDE; s++) begin
      d = rnd() | 32'h0000_0001;
      wr(s, REG_OUT_DBELL, d);
      rd(1 - s, REG_IN_DBELL, d, "in_dbell");
      rd(s, REG_OUT_DBELL, d, "out_dbell");
      rd(1 - s, REG_INT_STS, 32'h0000_0010, "dbell_sts");
      wr(1 - s, REG_IN_DBELL, RST_WORD);
      rd(1 - s, REG_IN_DBELL, d, "dbell_w0");
      wr(1 - s, REG_IN_DBELL, 32'hFFFF_FFFF);
      wr(1 - s, REG_INT_STS, 32'h0000_0010);
      wr(s, REG_OUT_DBELL, d);
      rd(1 - s, REG_IN_DBELL, RST_WORD, "dbell_no_rise");
      rd(1 - s, REG_INT_STS, RST_WORD, "dbell_sts_clr");
      wr(s, REG_OUT_DBELL, RST_WORD);
    end
    // Scratchpads through the direct port only
    for (int i = 0; i < NSCR; i++) begin
      d = rnd();
      wr(1, REG_SCRATCH0 + AW'(i), d);
      rd(0, REG_SCRATCH0 + AW'(i), d, "scratch");
      rd(1, REG_INT_STS, RST_WORD, "scratch_quiet");
    end
    // Reset, power and link events each set their own status bit
    for (int b = STS_OPP_RST; b < NSRC; b++) begin
      @(posedge ref_clk);
      {evt_link[1], evt_opp_pm[1], evt_opp_reset[1]} <= 8'h01 << (b - STS_OPP_RST);
      @(posedge ref_clk);
      {evt_link[1], evt_opp_pm[1], evt_opp_reset[1]} <= 8'h00;
      rd(1, REG_INT_STS, DW'(1) << b, "event_sts");
      wr(1, REG_INT_STS, DW'(1) << b);
    end
    // One MSI per rise of the request on the external side
    d = rnd();
    wr(1, REG_MSI_ADDR, d);
    wr(1, REG_MSI_DATA, ~d);
    wr(1, REG_IRQ_CFG, 32'h0000_0001);
    wr(1, REG_ROUTE_LOW, 32'h0000_0002);
    c0 = msi_cnt[1];
    wr(0, REG_OUT_MSG0, d);
    idle(4);
    `CHK("msi_addr", d, msi_addr[1])
    `CHK("msi_data", ~d, msi_data[1])
    `CHK("msi_once", c0 + 8'h01, msi_cnt[1])
    wr(0, REG_OUT_MSG0, ~d);
    idle(4);
    `CHK("msi_held", c0 + 8'h01, msi_cnt[1])
    wr(1, REG_INT_STS, 32'h0000_0001);
    wr(0, REG_OUT_MSG0, d);
    idle(4);
    `CHK("msi_again", c0 + 8'h02, msi_cnt[1])
    wr(1, REG_INT_STS, 32'h0000_0001);
    wr(1, REG_IRQ_CFG, RST_WORD);
    wr(0, REG_OUT_MSG0, d);
    idle(4);
    `CHK("msi_off", c0 + 8'h02, msi_cnt[1])
    // Legacy lines A to D with MSI still enabled
    wr(1, REG_IRQ_CFG, 32'h0000_0001);
    for (int l = 0; l < NLINE; l++) begin
      wr(1, REG_ROUTE_LOW, DW'({l[1:0], MODE_INTX}));
      idle(4);
      `CHK("intx_on", 4'h1 << l, intx_level[1])
      wr(1, REG_ROUTE_LOW, RST_WORD);
      idle(4);
      `CHK("intx_masked", 4'h0, intx_level[1])
    end
    wr(1, REG_ROUTE_LOW, 32'h0000_0009);
    wr(1, REG_INT_STS, 32'h0000_0001);
    idle(4);
    `CHK("intx_clr", 4'h0, intx_level[1])
    wr(1, REG_IRQ_CFG, 32'h0000_0003);
    wr(0, REG_OUT_MSG0, d);
    idle(4);
    `CHK("intx_dis", 4'h0, intx_level[1])
    wr(1, REG_IRQ_CFG, 32'h0000_0001);
    idle(4);
    `CHK("intx_enable", 4'h4, intx_level[1])
    // Attribute overrides on random traffic, all forced first
    for (int i = 0; i < 60; i++) begin
      if (i % 10 == 0) begin
        r = rnd();
        ctl = (i == 0) ? 4'hF : r[3:0];
        wr(0, REG_TLP_CTL, DW'(ctl));
        wr(1, REG_TLP_CTL, DW'(~ctl));
        rd(1, REG_TLP_CTL, DW'(ctl), "tlp_ctl");
      end
      r = rnd();
      @(posedge ref_clk);
      tlp_in_valid <= 1'b1;
      tlp_in_kind <= ntbipc_tlp_kind_t'(r[2:0] % 3'h5);
      {tlp_in_local, tlp_in_ro, tlp_in_ns} <= r[5:3];
      @(posedge ref_clk);
      tlp_in_valid <= 1'b0;
      #1;
      exp_ro = exp_attr(tlp_in_kind, tlp_in_local, tlp_in_ro, ctl[0], ctl[1]);
      exp_ns = exp_attr(tlp_in_kind, tlp_in_local, tlp_in_ns, ctl[2], ctl[3]);
      `CHK("tlp_ro", exp_ro, tlp_out_ro)
      `CHK("tlp_ns", exp_ns, tlp_out_ns)
    end
    end_sim();
  end
endmodule // testbench
